/* pkg/eem_chk_if.sv */
`timescale 1ns/100ps
// Carries one array unit to the checker and its verdict back
interface eem_chk_if;
  logic [63:0] data;
  logic [7:0]  check;
  logic        corr;
  logic        uncorr;
  modport mon (output data, output check, input corr, input uncorr);
  modport chk (input data, input check, output corr, output uncorr);
endinterface : eem_chk_if

/* pkg/eem_pkg.sv */
// Operation
// - Check every 8-byte array unit and detect 3-bit errors in it.
// - Repair 2-bit errors during the refresh write-back; never report them.
// - Checking is always on and covers every array read outside the special sector.
// - A 3-bit detection sets the uncorrectable flag in the status byte.
// - Capture register low 3 bytes hold the first failing unit address.
// - Later 3-bit errors leave the captured address untouched until cleared.
// - The 16-bit event counter adds one per 3-bit detection.
// - Counter clears on power-on, any reset, and clear command.
// - Status bit 4 shows a 3-bit detection since last clear; resets to 0.
// - Opcode 19h with unit address returns that unit's 3-bit detection status.
// - Special sector and status/configuration registers are never checked.
// - Status byte is read only through register-read opcode 65h.
// - Status byte bits other than bit 4 always read 0.
// - Opcode 1Bh clears flag, capture and counter without write enable.
// - Counter saturates at ffff.
// - Deep sleep loses counter and capture; both read zero after exit.
// - Unit query ignores the low three address bits; answers one byte.
package eem_pkg;
  localparam logic [7:0]  OP_UNIT_QUERY = 8'h19;
  localparam logic [7:0]  OP_CLEAR      = 8'h1b;
  localparam logic [7:0]  OP_REG_READ   = 8'h65;
  // Register-read addresses of the monitor registers
  localparam logic [23:0] RA_STATUS     = 24'h000010;
  localparam logic [23:0] RA_COUNTER    = 24'h000011;
  localparam logic [23:0] RA_CAPTURE    = 24'h000012;
  localparam int          UNCORR_BIT    = 4;
  localparam int          UNIT_LSB      = 3;
  localparam logic [15:0] CNT_MAX       = 16'hffff;
  localparam logic [4:0]  OPC_LAST      = 5'h07;
  localparam logic [4:0]  ADDR_LAST     = 5'h17;
  localparam logic [4:0]  DUMMY_LAST    = 5'h07;
  localparam int          UNIT_BYTES    = 8;
  typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} eem_state_e;
endpackage : eem_pkg

/* test/eem_host_model.sv */
`timescale 1ns/100ps
// Stand-in for the host on the serial pins and for the array's read path
module eem_host_model
  import eem_pkg::*;
(
  input  wire logic        clk,
  output logic             sck,
  output logic             cs_n,
  output logic             si,
  input  wire logic        so_out,
  input  wire logic        so_oe,
  input  wire logic        query_req,
  input  wire logic [23:0] query_addr,
  output logic             rd_valid,
  output logic             rd_special,
  output logic [23:0]      rd_unit_addr,
  output logic [63:0]      rd_data,
  output logic [7:0]       rd_check
);
  logic        so_q     = 1'h0;
  logic [23:0] bad_unit = 24'h000000;
  // A released line shows the inverse of its last value, never a held copy
  wire         so_w     = so_oe ? so_out : ~so_q;

  // Quiet pins at time zero
  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
    si = 1'h0;
    rd_valid = 1'h0;
    rd_special = 1'h0;
    rd_unit_addr = 24'h0;
    rd_data = 64'h0;
    rd_check = 8'h0;
  end

  always @(posedge clk) if (so_oe) so_q <= so_out;

  // Every change lands one step after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Data made from the address, nerr stored parity bits flipped; valid held n cycles
  task automatic read_unit(input logic [23:0] a, input int nerr, input logic sp, input int n);
    logic [63:0] v;
    v = {a, a, a[15:0]};
    rd_unit_addr = a;
    rd_data = v;
    for (int i = 0; i < UNIT_BYTES; i++) begin
      rd_check[i] = (^v[8*i +: 8]) ^ (i < nerr);
    end
    rd_special = sp;
    rd_valid = 1'h1;
    tick(n);
    rd_valid = 1'h0;
    rd_special = 1'h0;
  endtask : read_unit

  // Array answers a unit query well before the dummy clocks end
  always @(posedge clk) if (query_req) begin
    tick(2);
    read_unit(query_addr, (query_addr == bad_unit) ? 3 : 0, 1'h0, 1);
  end

  // Mode 0 frame: opcode, address and dummy MSB first, then a 32-bit answer; opcode 1Bh sends its opcode only
  task automatic frame(input logic [7:0] op, input logic [23:0] a, output logic [31:0] d);
    logic [39:0] b;
    b = {op, a, 8'h00};
    d = 32'h0;
    cs_n = 1'h0;
    tick(4);
    for (int i = 0; i < ((op == OP_CLEAR) ? 8 : 40); i++) begin
      si = b[39-i];
      tick(4);
      sck = 1'h1;
      tick(4);
      sck = 1'h0;
    end
    for (int i = 0; i < ((op == OP_CLEAR) ? 0 : 32); i++) begin
      tick(4);
      sck = 1'h1;
      d = {d[30:0], so_w};
      tick(4);
      sck = 1'h0;
    end
    tick(4);
    cs_n = 1'h1;
    tick(8);
  endtask : frame
endmodule : eem_host_model

/* test/tb.sv */
`timescale 1ns/100ps
module tb
  import eem_pkg::*;
;
  logic        clk, rst, deep_sleep_state, sck, cs_n, si, so_out, so_oe, query_req;
  logic        rd_valid, rd_special, wb_valid;
  logic [23:0] query_addr, rd_unit_addr, wb_addr;
  logic [63:0] rd_data, wb_data;
  logic [7:0]  rd_check;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          checked    = 0;

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  eem_monitor DUT (.clk, .rst, .sck, .cs_n, .si, .so_out, .so_oe, .rd_valid, .rd_special,
    .rd_unit_addr, .rd_data, .rd_check, .deep_sleep_state, .query_req, .query_addr,
    .wb_valid, .wb_addr, .wb_data);
  eem_host_model HOST (.clk, .sck, .cs_n, .si, .so_out, .so_oe, .query_req, .query_addr,
    .rd_valid, .rd_special, .rd_unit_addr, .rd_data, .rd_check);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk

  // Monitor registers are only reachable through the register-read opcode
  task automatic regs(input logic [7:0] s, input logic [15:0] c, input logic [23:0] t);
    HOST.frame(OP_REG_READ, RA_STATUS, d);
    chk(d, {s, 24'h0}, "status");
    HOST.frame(OP_REG_READ, RA_COUNTER, d);
    chk(d, {c, 16'h0}, "counter");
    HOST.frame(OP_REG_READ, RA_CAPTURE, d);
    chk(d, {8'h00, t}, "capture");
  endtask : regs

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; the unit queries also count as array reads
  initial begin
    rst = 1'h1;
    deep_sleep_state = 1'h0;
    HOST.tick(4);
    rst = 1'h0;
    HOST.tick(4);
    regs(8'h00, 16'h0, 24'h0);
    HOST.read_unit(24'h000300, 2, 1'h0, 1);
    chk(32'({wb_valid, wb_addr}), 32'({1'h1, 24'h000300}), "repair");
    chk(wb_data[63:32], 32'h00030000, "repair data high");
    chk(wb_data[31:0], 32'h03000300, "repair data low");
    HOST.tick(1);
    HOST.read_unit(24'h000400, 3, 1'h1, 1);
    regs(8'h00, 16'h0, 24'h0);
    HOST.read_unit(24'h000128, 3, 1'h0, 1);
    HOST.tick(1);
    HOST.read_unit(24'h000200, 3, 1'h0, 2);
    regs(8'h10, 16'h3, 24'h000128);
    HOST.bad_unit = 24'h000128;
    HOST.frame(OP_UNIT_QUERY, 24'h00012f, d);
    chk(32'(d[31:24]), 32'h10, "unit flagged");
    HOST.frame(OP_UNIT_QUERY, 24'h000041, d);
    chk(32'(d[31:24]), 32'h00, "unit clean");
    HOST.frame(OP_CLEAR, 24'h0, d);
    regs(8'h00, 16'h0, 24'h0);
    HOST.read_unit(24'h000500, 3, 1'h0, 65540);
    regs(8'h10, 16'hffff, 24'h000500);
    deep_sleep_state = 1'h1;
    HOST.tick(3);
    deep_sleep_state = 1'h0;
    regs(8'h00, 16'h0, 24'h0);
    HOST.read_unit(24'h000600, 3, 1'h0, 1);
    rst = 1'h1;
    HOST.tick(2);
    rst = 1'h0;
    HOST.tick(4);
    regs(8'h00, 16'h0, 24'h0);
    conclude();
  end

  // Cuts a hang short
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
endmodule : tb

/* verilog/eem_checker.sv */
`timescale 1ns/100ps
module eem_checker
  import eem_pkg::*;
(
  eem_chk_if.chk bus
);
  logic [7:0] syndrome;
  logic [3:0] weight;

  ////////////////////////////////////////////////////////////////////////
  // One check bit per byte lane over the 64-bit unit
  for (genvar i = 0; i < UNIT_BYTES; i++) begin : g_lane
    assign syndrome[i] = (^bus.data[8*i +: 8]) ^ bus.check[i];
  end

  // Mismatch weight sorts the unit into repairable or not
  always_comb begin
    weight = 4'h0;
    for (int i = 0; i < UNIT_BYTES; i++) begin
      weight = weight + {3'h0, syndrome[i]};
    end
  end

  assign bus.corr   = (weight != 4'h0) && (weight < 4'h3);
  assign bus.uncorr = (weight >= 4'h3);
endmodule : eem_checker

/* verilog/eem_monitor.sv */
`timescale 1ns/100ps
module eem_monitor
  import eem_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si,
  output logic             so_out,
  output logic             so_oe,
  input  wire logic        rd_valid,
  input  wire logic        rd_special,
  input  wire logic [23:0] rd_unit_addr,
  input  wire logic [63:0] rd_data,
  input  wire logic [7:0]  rd_check,
  input  wire logic        deep_sleep_state,
  output logic             query_req,
  output logic [23:0]      query_addr,
  output logic             wb_valid,
  output logic [23:0]      wb_addr,
  output logic [63:0]      wb_data
);
  eem_chk_if chk_bus ();

  eem_checker u_checker (
    .bus (chk_bus)
  );

  eem_state_e  state_reg;
  logic [4:0]  bit_cnt_reg;
  logic [23:0] in_sh_reg;
  logic [7:0]  op_reg;
  logic [23:0] addr_reg;
  logic [31:0] out_sh_reg;
  logic        so_reg;
  logic        sck_s1, sck_s2, sck_s3, cs_s1, cs_s2, si_s1, si_s2;
  logic        flag_reg, flag_next;
  logic        captured_reg, captured_next;
  logic [23:0] capture_reg, capture_next;
  logic [15:0] count_reg, count_next;
  logic        query_hit_reg;
  logic        query_req_reg;
  logic [23:0] query_addr_reg;
  logic        wb_valid_reg;
  logic [23:0] wb_addr_reg;
  logic [63:0] wb_data_reg;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the third sck stage only serves edge detection
  always_ff @(posedge clk) begin
    sck_s1 <= sck;
    sck_s2 <= sck_s1;
    sck_s3 <= sck_s2;
    cs_s1  <= cs_n;
    cs_s2  <= cs_s1;
    si_s1  <= si;
    si_s2  <= si_s1;
  end

  // Edge strobes and command decode
  wire        sck_rise   = sck_s2 & ~sck_s3 & ~cs_s2;
  wire        sck_fall   = ~sck_s2 & sck_s3 & ~cs_s2;
  wire [7:0]  opc_now    = {in_sh_reg[6:0], si_s2};
  wire [23:0] addr_now   = {in_sh_reg[22:0], si_s2};
  wire        opc_done   = sck_rise && (state_reg == ST_OPC) && (bit_cnt_reg == OPC_LAST);
  wire        addr_done  = sck_rise && (state_reg == ST_ADDR) && (bit_cnt_reg == ADDR_LAST);
  wire        dummy_done = sck_rise && (state_reg == ST_DUMMY) && (bit_cnt_reg == DUMMY_LAST);
  wire        clear_cmd  = opc_done && (opc_now == OP_CLEAR); // no write latch needed
  wire        op_known   = (opc_now == OP_UNIT_QUERY) || (opc_now == OP_REG_READ);

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer; raising chip select always returns to opcode phase
  always_ff @(posedge clk) begin
    if (rst || cs_s2) begin
      state_reg   <= ST_OPC;
      bit_cnt_reg <= 5'h00;
    end else if (sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      unique case (state_reg)
        ST_OPC: begin
          if (bit_cnt_reg == OPC_LAST) begin
            state_reg   <= op_known ? ST_ADDR : ST_IGNORE;
            bit_cnt_reg <= 5'h00;
          end
        end
        ST_ADDR: begin
          if (bit_cnt_reg == ADDR_LAST) begin
            state_reg   <= ST_DUMMY;
            bit_cnt_reg <= 5'h00;
          end
        end
        ST_DUMMY: begin
          if (bit_cnt_reg == DUMMY_LAST) begin
            state_reg <= ST_DATA;
          end
        end
        ST_DATA:   bit_cnt_reg <= 5'h00;
        ST_IGNORE: bit_cnt_reg <= 5'h00;
      endcase
    end
  end

  // Serial input shifter, latched opcode and address
  always_ff @(posedge clk) begin
    if (rst) begin
      in_sh_reg <= 24'h000000;
      op_reg    <= 8'h00;
      addr_reg  <= 24'h000000;
    end else if (sck_rise) begin
      in_sh_reg <= addr_now;
      if (opc_done) op_reg <= opc_now;
      if (addr_done) addr_reg <= addr_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Answer selection; the status byte is only reachable via opcode 65h
  wire [7:0]  status_byte = 8'h01 << UNCORR_BIT & {8{flag_reg}};
  wire [7:0]  unit_byte   = 8'h01 << UNCORR_BIT & {8{query_hit_reg}};
  wire [31:0] capture_wd  = {8'h00, capture_reg};
  wire [31:0] reg_word    = (addr_reg == RA_STATUS)  ? {status_byte, 24'h000000} :
                            (addr_reg == RA_COUNTER) ? {count_reg, 16'h0000} :
                            (addr_reg == RA_CAPTURE) ? capture_wd : 32'h00000000;
  wire [31:0] read_word   = (op_reg == OP_UNIT_QUERY) ? {unit_byte, 24'h000000} : reg_word;

  // Output shifter: loads after the dummy cycles, drives on falling sck
  always_ff @(posedge clk) begin
    if (rst || cs_s2) begin
      out_sh_reg <= 32'h00000000;
      so_reg     <= 1'b0;
    end else if (dummy_done) begin
      out_sh_reg <= read_word;
    end else if (sck_fall && state_reg == ST_DATA) begin
      so_reg     <= out_sh_reg[31];
      out_sh_reg <= {out_sh_reg[30:0], 1'b0};
    end
  end

  assign so_out = so_reg;
  assign so_oe  = (state_reg == ST_DATA) && !cs_s2;

  ////////////////////////////////////////////////////////////////////////
  // Unit query launch: low three address bits are dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      query_req_reg  <= 1'b0;
      query_addr_reg <= 24'h000000;
    end else begin
      query_req_reg <= addr_done && (op_reg == OP_UNIT_QUERY);
      if (addr_done) query_addr_reg <= {addr_now[23:UNIT_LSB], 3'h0};
    end
  end

  assign query_req  = query_req_reg;
  assign query_addr = query_addr_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checker feed; no enable exists, every normal array read is checked
  assign chk_bus.data  = rd_data;
  assign chk_bus.check = rd_check;

  wire normal_rd = rd_valid && !rd_special;
  wire unc_evt   = normal_rd && chk_bus.uncorr;
  wire cor_evt   = normal_rd && chk_bus.corr;
  wire wipe      = clear_cmd || deep_sleep_state;

  // Sticky state; a detection in the clearing cycle survives the clear
  always_comb begin
    flag_next     = wipe ? 1'b0 : flag_reg;
    captured_next = wipe ? 1'b0 : captured_reg;
    capture_next  = wipe ? 24'h000000 : capture_reg;
    count_next    = wipe ? 16'h0000 : count_reg;
    if (unc_evt) begin
      flag_next = 1'b1;
      if (!captured_next) begin
        captured_next = 1'b1;
        capture_next  = rd_unit_addr;
      end
      if (count_next != CNT_MAX) count_next = count_next + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_reg     <= 1'b0;
      captured_reg <= 1'b0;
      capture_reg  <= 24'h000000;
      count_reg    <= 16'h0000;
    end else begin
      flag_reg     <= flag_next;
      captured_reg <= captured_next;
      capture_reg  <= capture_next;
      count_reg    <= count_next;
    end
  end

  // Query verdict and repair write-back; 2-bit cases raise no flag
  always_ff @(posedge clk) begin
    if (rst) begin
      query_hit_reg <= 1'b0;
      wb_valid_reg  <= 1'b0;
      wb_addr_reg   <= 24'h000000;
      wb_data_reg   <= 64'h0;
    end else begin
      if (normal_rd && rd_unit_addr == query_addr_reg) query_hit_reg <= chk_bus.uncorr;
      wb_valid_reg <= cor_evt;
      if (cor_evt) begin
        wb_addr_reg <= rd_unit_addr;
        wb_data_reg <= rd_data;
      end
    end
  end

  assign wb_valid = wb_valid_reg;
  assign wb_addr  = wb_addr_reg;
  assign wb_data  = wb_data_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_FLAG_SET: assert property (@(posedge clk) disable iff (rst)
    unc_evt |=> flag_reg) else $error("flag not set by 3-bit error");
  AST_CAPTURE_FIRST: assert property (@(posedge clk) disable iff (rst)
    unc_evt && !captured_reg |=> capture_reg == $past(rd_unit_addr))
    else $error("first address not captured");
  AST_CAPTURE_HOLD: assert property (@(posedge clk) disable iff (rst)
    captured_reg && !wipe |=> $stable(capture_reg)) else $error("capture overwritten");
  AST_COUNT_INC: assert property (@(posedge clk) disable iff (rst)
    unc_evt && !wipe && count_reg != CNT_MAX |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not step");
  AST_COUNT_SAT: assert property (@(posedge clk) disable iff (rst)
    count_reg == CNT_MAX && !wipe |=> count_reg == CNT_MAX) else $error("counter wrapped");
  AST_WIPE: assert property (@(posedge clk) disable iff (rst)
    wipe && !unc_evt |=> count_reg == 16'h0000 && !flag_reg && capture_reg == 24'h000000)
    else $error("clear incomplete");
  AST_SPECIAL_IGNORED: assert property (@(posedge clk) disable iff (rst)
    rd_valid && rd_special && !wipe |=> $stable(count_reg) && $stable(flag_reg))
    else $error("special read was checked");
  AST_REPAIR_QUIET: assert property (@(posedge clk) disable iff (rst)
    cor_evt && !flag_reg |=> wb_valid && !flag_reg) else $error("2-bit repair misbehaved");
  // Watches the loaded answer word, so a wrong mask in the read path is caught too
  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (rst)
    dummy_done && op_reg == OP_REG_READ && addr_reg == RA_STATUS
    |=> (out_sh_reg[31:24] & ~(8'h01 << UNCORR_BIT)) == 8'h00) else $error("reserved bit set");
  // The array fetch is launched while the dummy clocks still run; sck rate is the host's
  AST_QUERY_ALIGN: assert property (@(posedge clk) disable iff (rst)
    query_req |-> query_addr[2:0] == 3'h0 && state_reg == ST_DUMMY)
    else $error("query misaligned");

  COV_UNCORR: cover property (@(posedge clk) disable iff (rst) unc_evt);
  COV_REPAIR: cover property (@(posedge clk) disable iff (rst) cor_evt);
  COV_CLEAR:  cover property (@(posedge clk) disable iff (rst) clear_cmd && flag_reg);
  COV_SAT:    cover property (@(posedge clk) disable iff (rst) count_reg == CNT_MAX);
endmodule : eem_monitor
